// ---- uart_rx_pkg.sv ----
// shared constants and carrier types for the serial receive block
package uart_rx_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [3:0] rx_data_register_off = 4'h0;
	localparam logic [3:0] rx_status_control_register_off = 4'h4;
	localparam logic [3:0] interrupt_control_register_off = 4'h8;
	localparam logic [3:0] baud_divisor_off = 4'hc;

	// ****************************************
	// field positions
	// ****************************************
	localparam int serial_port_enable_pos = 7;
	localparam int continuous_receive_enable_pos = 4;
	localparam int framing_error_bit_pos = 2;
	localparam int overrun_error_bit_pos = 1;
	localparam int rx_pending_flag_pos = 0;
	localparam int global_interrupt_enable_pos = 7;
	localparam int peripheral_interrupt_enable_pos = 6;
	localparam int rx_interrupt_enable_pos = 5;

	// ****************************************
	// reset values and timing
	// ****************************************
	localparam logic [15:0] baud_divisor_rst = 16'h01b2; // 115200 baud at 50 MHz
	localparam logic [7:0] ctrl_rst = 8'h00;
	localparam logic [1:0] axi_resp_okay = 2'h0;
	localparam logic [1:0] axi_resp_slverr = 2'h2;

	// one received character with its framing status
	typedef struct packed {
		logic framing_error_bit;
		logic [7:0] data;
	} rx_entry_t;

	// receiver states
	typedef enum logic [2:0] {
		st_idle,
		st_start,
		st_data,
		st_stop
	} rx_state_t;

endpackage

// ---- uart_receive_fifo_errors.sv ----
// receive path of an asynchronous serial port with two-entry fifo and error flags

// Summary of operation
// - low stop sample sets framing error
// - completed character enters fifo, pending set
// - data read returns oldest, pops it
// - no characters accepted during overrun
// - pending when enabled and fifo nonempty
// - pending flag read-only, follows occupancy
// - interrupt needs all three enables set
// - framing status stored per fifo entry
// - visible framing bit is oldest's, read-only
// - framing error keeps receiver running
// - reading advances framing status too
// - port enable clear resets, clears framing
// - receive enable clear keeps framing status
// - framing error alone raises no interrupt
// - all-error fifo keeps framing bit set
// - two entries; third character sets overrun
// - held characters readable after overrun
// - overrun cleared by either enable clear
module uart_receive_fifo_errors #(
	parameter int depth = 2,
	parameter int data_bits = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial line and interrupt
	input wire logic rx_line,
	output logic irq
);

	// ****************************************
	// elaboration checks
	// ****************************************
	if (depth != 2) begin : g_bad_depth
		$error("receive fifo depth must be two");
	end
	if (data_bits != 8) begin : g_bad_bits
		$error("character width must be eight");
	end

	// ****************************************
	// control registers
	// ****************************************
	logic [15:0] baud_div_r;
	logic serial_port_enable_r;
	logic continuous_receive_enable_r;
	logic global_interrupt_enable_r;
	logic peripheral_interrupt_enable_r;
	logic rx_interrupt_enable_r;
	logic overrun_error_bit_r;
	logic port_rst;

	// ****************************************
	// fifo storage
	// ****************************************
	uart_rx_pkg::rx_entry_t fifo_mem_r [depth];
	logic rd_ptr_r;
	logic wr_ptr_r;
	logic [1:0] count_r;
	logic fifo_push;
	logic fifo_pop;
	logic fifo_full;
	logic fifo_empty;
	uart_rx_pkg::rx_entry_t fifo_head;

	// ****************************************
	// receiver
	// ****************************************
	uart_rx_pkg::rx_state_t state_r;
	logic [15:0] tick_cnt_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] receive_shift_register_r;
	logic rx_sync1_r;
	logic rx_sync2_r;
	logic tick_done;
	logic half_done;
	logic char_done;
	logic char_framing_error_bit;

	// ****************************************
	// axi slave state
	// ****************************************
	logic aw_held_r;
	logic w_held_r;
	logic [3:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_fire;
	logic rd_fire;
	logic wr_ctrl;
	logic wr_intc;
	logic wr_baud;
	logic wr_hit;
	logic rd_data_sel;
	logic rd_hit;
	logic [31:0] rd_word;
	logic [7:0] status_byte;
	logic [7:0] intc_byte;
	logic irq_nxt;

	// port enable low holds the receiver, fifo and overrun flag in reset
	// port reset path
	assign port_rst = !aresetn || !serial_port_enable_r;

	// ****************************************
	// line synchroniser
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_sync1_r <= 1'b1;
			rx_sync2_r <= 1'b1;
		end else begin
			rx_sync1_r <= rx_line;
			rx_sync2_r <= rx_sync1_r;
		end
	end

	// bit timing: full period and half period for start-bit centring
	assign tick_done = (tick_cnt_r == baud_div_r);
	assign half_done = (tick_cnt_r == {1'b0, baud_div_r[15:1]});

	assign char_framing_error_bit = !rx_sync2_r;
	assign char_done = (state_r == uart_rx_pkg::st_stop) && tick_done;

	// ****************************************
	// receive state machine
	// ****************************************
	// start, lsb-first data, stop
	always_ff @(posedge aclk) begin
		if (port_rst || !continuous_receive_enable_r) begin
			state_r <= uart_rx_pkg::st_idle;
			tick_cnt_r <= 16'h0000;
			bit_cnt_r <= 3'h0;
			receive_shift_register_r <= 8'h00;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
			case (state_r)
				uart_rx_pkg::st_idle: begin
					tick_cnt_r <= 16'h0000;
					if (!rx_sync2_r) begin
						state_r <= uart_rx_pkg::st_start;
					end
				end
				uart_rx_pkg::st_start: begin
					if (half_done) begin
						tick_cnt_r <= 16'h0000;
						// glitch shorter than half a bit is dropped
						state_r <= rx_sync2_r ? uart_rx_pkg::st_idle : uart_rx_pkg::st_data;
					end
				end
				uart_rx_pkg::st_data: begin
					if (tick_done) begin
						tick_cnt_r <= 16'h0000;
						receive_shift_register_r <= {rx_sync2_r, receive_shift_register_r[7:1]};
						bit_cnt_r <= bit_cnt_r + 3'h1;
						if (bit_cnt_r == 3'h7) begin
							state_r <= uart_rx_pkg::st_stop;
						end
					end
				end
				uart_rx_pkg::st_stop: begin
					if (tick_done) begin
						tick_cnt_r <= 16'h0000;
						state_r <= uart_rx_pkg::st_idle;
					end
				end
				default: begin
					state_r <= uart_rx_pkg::st_idle;
				end
			endcase
		end
	end

	// ****************************************
	// fifo control
	// ****************************************
	assign fifo_full = (count_r == 2'h2);
	assign fifo_empty = (count_r == 2'h0);
	assign fifo_push = char_done && !fifo_full && !overrun_error_bit_r;
	assign fifo_pop = rd_fire && rd_data_sel && !fifo_empty;
	assign fifo_head = fifo_mem_r[rd_ptr_r];

	always_ff @(posedge aclk) begin
		if (port_rst) begin
			for (int i = 0; i < depth; i++) begin
				fifo_mem_r[i] <= '0;
			end
		end else if (fifo_push) begin
			fifo_mem_r[wr_ptr_r] <= '{framing_error_bit: char_framing_error_bit, data: receive_shift_register_r};
		end
	end

	always_ff @(posedge aclk) begin
		if (port_rst) begin
			rd_ptr_r <= 1'b0;
			wr_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (fifo_push) begin
				wr_ptr_r <= !wr_ptr_r;
			end
			if (fifo_pop) begin
				rd_ptr_r <= !rd_ptr_r;
			end
			count_r <= count_r + {1'b0, fifo_push} - {1'b0, fifo_pop};
		end
	end

	always_ff @(posedge aclk) begin
		if (port_rst || !continuous_receive_enable_r) begin
			overrun_error_bit_r <= 1'b0;
		end else if (char_done && fifo_full) begin
			overrun_error_bit_r <= 1'b1;
		end
	end

	// ****************************************
	// axi write path
	// ****************************************
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_ctrl = wr_fire && (aw_addr_r == uart_rx_pkg::rx_status_control_register_off);
	assign wr_intc = wr_fire && (aw_addr_r == uart_rx_pkg::interrupt_control_register_off);
	assign wr_baud = wr_fire && (aw_addr_r == uart_rx_pkg::baud_divisor_off);
	assign wr_hit = wr_ctrl || wr_intc || wr_baud;

	// address and data captured in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && s_axi_awvalid && !s_axi_awready;
			s_axi_wready <= !w_held_r && s_axi_wvalid && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
		end
	end

	// write response; data register and unmapped give slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= uart_rx_pkg::axi_resp_okay;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? uart_rx_pkg::axi_resp_okay : uart_rx_pkg::axi_resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// pending and error bits not writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_port_enable_r <= uart_rx_pkg::ctrl_rst[uart_rx_pkg::serial_port_enable_pos];
			continuous_receive_enable_r <= 1'b0;
			global_interrupt_enable_r <= 1'b0;
			peripheral_interrupt_enable_r <= 1'b0;
			rx_interrupt_enable_r <= 1'b0;
			baud_div_r <= uart_rx_pkg::baud_divisor_rst;
		end else begin
			if (wr_ctrl && w_strb_r[0]) begin
				serial_port_enable_r <= w_data_r[uart_rx_pkg::serial_port_enable_pos];
				continuous_receive_enable_r <=
					w_data_r[uart_rx_pkg::continuous_receive_enable_pos];
			end
			if (wr_intc && w_strb_r[0]) begin
				global_interrupt_enable_r <= w_data_r[uart_rx_pkg::global_interrupt_enable_pos];
				peripheral_interrupt_enable_r <=
					w_data_r[uart_rx_pkg::peripheral_interrupt_enable_pos];
				rx_interrupt_enable_r <= w_data_r[uart_rx_pkg::rx_interrupt_enable_pos];
			end
			if (wr_baud) begin
				if (w_strb_r[0]) begin
					baud_div_r[7:0] <= w_data_r[7:0];
				end
				if (w_strb_r[1]) begin
					baud_div_r[15:8] <= w_data_r[15:8];
				end
			end
		end
	end

	// ****************************************
	// axi read path
	// ****************************************
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_data_sel = ({s_axi_araddr[3:2], 2'b00} == uart_rx_pkg::rx_data_register_off);
	assign rd_hit = rd_data_sel
		|| ({s_axi_araddr[3:2], 2'b00} == uart_rx_pkg::rx_status_control_register_off)
		|| ({s_axi_araddr[3:2], 2'b00} == uart_rx_pkg::interrupt_control_register_off)
		|| ({s_axi_araddr[3:2], 2'b00} == uart_rx_pkg::baud_divisor_off);

	// head status shown, empty reads zero
	assign status_byte = {serial_port_enable_r, 2'b00, continuous_receive_enable_r, 1'b0,
		fifo_head.framing_error_bit && !fifo_empty, overrun_error_bit_r,
		continuous_receive_enable_r && !fifo_empty};
	assign intc_byte = {global_interrupt_enable_r, peripheral_interrupt_enable_r,
		rx_interrupt_enable_r, 5'h00};

	// read word selection
	always_comb begin
		rd_word = 32'h0000_0000;
		case ({s_axi_araddr[3:2], 2'b00})
			uart_rx_pkg::rx_data_register_off: rd_word = {24'h00_0000, fifo_head.data};
			uart_rx_pkg::rx_status_control_register_off: rd_word = {24'h00_0000, status_byte};
			uart_rx_pkg::interrupt_control_register_off: rd_word = {24'h00_0000, intc_byte};
			uart_rx_pkg::baud_divisor_off: rd_word = {16'h0000, baud_div_r};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// single outstanding read, answer one edge after address taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= uart_rx_pkg::axi_resp_okay;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? uart_rx_pkg::axi_resp_okay : uart_rx_pkg::axi_resp_slverr;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// interrupt gate
	// ****************************************
	// three enables gate request
	assign irq_nxt = continuous_receive_enable_r && !fifo_empty && rx_interrupt_enable_r
		&& peripheral_interrupt_enable_r && global_interrupt_enable_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_nxt;
		end
	end

endmodule

// ---- uart_rx_chk_sva.sv ----
// bus handshake and interrupt gating checks for the serial receive block
module uart_rx_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read side
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// shadow of the interrupt enables
	// ****************************************
	logic [3:0] aw_sh;
	logic [31:0] w_sh;
	logic aw_got, w_got;
	logic [7:0] intc_sh;
	wire en_all = &intc_sh[7:5];
	// track each write until both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'h0;
			w_got <= 1'h0;
			intc_sh <= 8'h00;
		end else if (aw_got && w_got) begin
			aw_got <= 1'h0;
			w_got <= 1'h0;
			if (aw_sh[3:2] == 2'h2) intc_sh <= w_sh[7:0];
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_got <= 1'h1;
			if (s_axi_wvalid && s_axi_wready) w_got <= 1'h1;
		end
	end
	// capture address and data at their handshakes
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) aw_sh <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) w_sh <= s_axi_wdata;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		aw_got && w_got;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_write_answer: assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
		else $error("write response missing");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data not on next cycle");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_ar_single: assert property (s_axi_rvalid && !s_axi_rready |=> !s_axi_arready)
		else $error("read taken while data outstanding");
	chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	chk_data_wr_refused: assert property ($rose(s_axi_bvalid) && aw_sh[3:2] == 2'h0
		|-> s_axi_bresp == uart_rx_pkg::axi_resp_slverr)
		else $error("write to data register not refused");
	chk_irq_gated: assert property (irq |-> en_all || $past(en_all) || $past(en_all, 2))
		else $error("interrupt without all enables");
	chk_reset_quiet: assert property (disable iff (1'h0) !aresetn
		|=> !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset");
endmodule
bind uart_receive_fifo_errors uart_rx_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// ---- uart_line_model.sv ----
// remote serial transmitter model driving the receive line
module uart_line_model (
	// clock and serial line
	input wire logic aclk,
	output logic rx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	int bit_cycles = 16;
	initial rx_line = 1'h1;
	task automatic send(input logic [7:0] d, input logic stop_ok);
		logic [9:0] f;
		f = {stop_ok, d, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge aclk);
			rx_line <= f[i];
			repeat (bit_cycles - 1) @(posedge aclk);
		end
		@(posedge aclk);
		rx_line <= 1'h1;
		repeat (2 * bit_cycles) @(posedge aclk);
	endtask
endmodule

// ---- uart_receive_fifo_errors_tb.sv ----
// self-checking bench for the serial receive block
module uart_receive_fifo_errors_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// signals and reference model state
	// ****************************************
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, got;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, rx_line, irq;
	logic [1:0] bresp, rresp, resp;
	logic spe = 1'h0, cre = 1'h0, ovr = 1'h0;
	logic [8:0] q[$];
	int fails = 0, checks_done = 0;
	// free-running clock
	always #10 aclk = ~aclk;
	uart_receive_fifo_errors dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_line(rx_line), .irq(irq));
	uart_line_model line (.aclk(aclk), .rx_line(rx_line));
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	// bus write, model follows control writes
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		int w;
		n = 0;
		w = int'($urandom % 5);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= (w == 0);
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			// late response acceptance exercises the hold checks
			if (n >= w && !bready) bready <= 1'h1;
		end while (!(bvalid === 1'h1 && bready === 1'h1) && n < 64);
		chk("wr_handshake", 32'h1, {31'h0, bvalid && bready});
		resp = bresp;
		bready <= 1'h0;
		if (a == 4'h4) begin
			spe = d[7];
			cre = d[4];
			if (!spe) q.delete();
			if (!spe || !cre) ovr = 1'h0;
		end
	endtask
	// bus read
	task automatic rd(input logic [3:0] a);
		int n;
		int w;
		n = 0;
		w = int'($urandom % 5);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= (w == 0);
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'h0;
			// late data acceptance exercises the hold checks
			if (n >= w && !rready) rready <= 1'h1;
		end while (!(rvalid === 1'h1 && rready === 1'h1) && n < 64);
		chk("rd_handshake", 32'h1, {31'h0, rvalid && rready});
		got = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask
	// expected status word from the model
	function automatic logic [31:0] st_exp();
		logic fe;
		fe = (q.size() > 0) ? q[0][8] : 1'h0;
		return {24'h0, spe, 2'h0, cre, 1'h0, fe, ovr, spe && cre && q.size() > 0};
	endfunction
	task automatic stat();
		rd(4'h4);
		chk("status", st_exp(), got);
		chk("rresp", {30'h0, uart_rx_pkg::axi_resp_okay}, {30'h0, resp});
	endtask
	task automatic pop();
		logic [8:0] e;
		rd(4'h0);
		if (q.size() > 0) begin
			e = q.pop_front();
			chk("data", {24'h0, e[7:0]}, got);
		end
	endtask
	// send one character and let the model receive it
	task automatic snd(input logic ok);
		logic [7:0] d;
		d = 8'($urandom);
		line.send(d, ok);
		if (spe && cre && !ovr) begin
			if (q.size() < 2) q.push_back({!ok, d});
			else ovr = 1'h1;
		end
	endtask
	task automatic irqchk(input logic e);
		repeat (3) @(posedge aclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (50000) @(posedge aclk);
		fails++;
		end_of_test();
	end
	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		void'($urandom(32'h699382ab));
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rd(4'hc);
		chk("baud", {16'h0, uart_rx_pkg::baud_divisor_rst}, got);
		rd(4'h8);
		chk("intc", 32'h0, got);
		stat();
		wr(4'h0, 32'h55);
		chk("data_wr_resp", {30'h0, uart_rx_pkg::axi_resp_slverr}, {30'h0, resp});
		wr(4'hc, 32'hf);
		wr(4'h4, 32'h87);
		stat();
		$display("test registers done");
		wr(4'h4, 32'h90);
		snd(1'h1);
		stat();
		snd(1'h0);
		stat();
		irqchk(1'h0);
		wr(4'h4, 32'h91);
		stat();
		for (int i = 0; i < 8; i++) begin
			wr(4'h8, 32'(i) << 5);
			irqchk(i == 7);
		end
		stat();
		pop();
		stat();
		pop();
		stat();
		irqchk(1'h0);
		$display("test fifo done");
		for (int i = 0; i < 4; i++) snd(1'h1);
		stat();
		pop();
		pop();
		stat();
		wr(4'h4, 32'h80);
		stat();
		wr(4'h4, 32'h90);
		snd(1'h0);
		snd(1'h0);
		pop();
		stat();
		wr(4'h4, 32'h80);
		stat();
		wr(4'h4, 32'h90);
		snd(1'h1);
		snd(1'h1);
		stat();
		wr(4'h4, 32'h10);
		stat();
		$display("test errors done");
		end_of_test();
	end
endmodule
